// file: hw/can_filt_defs.svh
// Purpose: register map and field constants of the acceptance filter
// Assumes: APB byte addresses, one 32-bit word per register
// Notes:   16-bit registers sit in the low half of each word
`ifndef CAN_FILT_DEFS_SVH
`define CAN_FILT_DEFS_SVH

`define CF_NUM_FILTERS      16
`define CF_NUM_MASKS        3
`define CF_NUM_BUFFERS      32
`define CF_ADDR_W           12

`define CF_OFS_FLT_STD      12'h000
`define CF_OFS_FLT_EXT      12'h040
`define CF_OFS_MSEL_LO      12'h080
`define CF_OFS_MSEL_HI      12'h084
`define CF_OFS_MSK_STD      12'h088
`define CF_OFS_MSK_EXT      12'h094
`define CF_OFS_FULL_LO      12'h0A0
`define CF_OFS_FULL_HI      12'h0A4
`define CF_OFS_OVF_LO       12'h0A8
`define CF_OFS_OVF_HI       12'h0AC
`define CF_OFS_FLT_EN       12'h0B0
`define CF_OFS_BUF_PTR      12'h0B4
`define CF_OFS_IRQ_STAT     12'h0C4
`define CF_OFS_IRQ_MASK     12'h0C8

`define CF_STD_WMASK        16'hFFEB
`define CF_STD_SID_LSB      5
`define CF_STD_TYPE_BIT     3
`define CF_FLT_EN_RESET     16'hFFFF
`define CF_PTR_FIFO         4'hF
`define CF_IRQ_ACCEPT       0
`define CF_IRQ_OVERFLOW     1

`endif

// file: hw/can_filt_pkg.sv
// Purpose: types shared by the acceptance filter
// Assumes: nothing
// Notes:   constants live in can_filt_defs.svh
`default_nettype none
package can_filt_pkg;
  typedef logic [15:0] reg16_type;
  typedef enum logic [1:0] {
    MASK_SRC_0   = 2'b00,
    MASK_SRC_1   = 2'b01,
    MASK_SRC_2   = 2'b10,
    MASK_SRC_RSV = 2'b11
  } mask_source_type;
endpackage
`default_nettype wire

// file: hw/can_acceptance_filter_rx_status.sv
// Purpose: CAN receive acceptance filtering and receive buffer status
// Assumes: rx_* inputs come from logic on pclk; APB answers at once
// Notes:   one frame may be offered per cycle; result appears a cycle later
`include "can_filt_defs.svh"
`default_nettype none

// How it works
// - sixteen filters, each with standard id, extended id, type select
// - included standard id bits must equal the filter's stored bits
// - included extended id bits 17..0 must equal the filter's bits
// - type check on: filter type select picks extended or standard only
// - type check off: either frame type accepted on identifier match
// - mask standard bit one compares that bit, zero ignores it
// - mask extended bit one compares that bit, zero ignores it
// - two-bit source picks mask 0, 1 or 2; code three is reserved
// - mask sources packed two bits per filter in two registers
// - full flag per buffer, set when a message is written there
// - overflow flag set when a message targets a full buffer
// - bits 4 and 2 of standard id registers read zero
// - per filter enable, all set after reset, gates acceptance
// - four-bit pointer picks buffer 0..14, all ones picks the fifo
// - number of the hitting filter is given with each buffer write
module can_acceptance_filter_rx_status (
  // clock and reset
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  // apb slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [`CF_ADDR_W-1:0]  paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  // decoded frame from the bit-stream receiver
  input  wire logic                   rx_valid,
  input  wire logic                   rx_ext,
  input  wire logic [10:0]            rx_sid,
  input  wire logic [17:0]            rx_eid,
  input  wire logic [4:0]             fifo_buffer_index,
  // buffer write request towards the message store
  output logic                        buf_wr_valid,
  output logic      [4:0]             buf_wr_index,
  output logic      [4:0]             hit_filter_number,
  // interrupt
  output logic                        irq
);

  localparam int NF = `CF_NUM_FILTERS;
  localparam int NM = `CF_NUM_MASKS;

  // register storage
  can_filt_pkg::reg16_type flt_std_q [NF];
  can_filt_pkg::reg16_type flt_ext_q [NF];
  can_filt_pkg::reg16_type msk_std_q [NM];
  can_filt_pkg::reg16_type msk_ext_q [NM];
  logic [31:0]             mask_sel_q;
  logic [15:0]             filter_accept_enable_q;
  logic [63:0]             buf_ptr_q;
  logic [31:0]             rx_buffer_full_flag_q;
  logic [31:0]             rx_buffer_overflow_flag_q;
  logic [1:0]              irq_stat_q;
  logic [1:0]              irq_mask_q;
  logic                    buf_wr_valid_q;
  logic [4:0]              buf_wr_index_q;
  logic [4:0]              hit_num_q;

  // bus decode
  logic                    acc;
  logic                    wr;
  logic                    rd;
  logic                    hit_std;
  logic                    hit_ext;
  logic                    hit_mstd;
  logic                    hit_mext;
  logic                    hit_ptr;
  logic [3:0]              word_idx;
  logic                    mapped;
  logic [15:0]             rdata16;

  assign acc      = psel & penable;
  assign wr       = acc & pwrite;
  assign rd       = acc & ~pwrite;
  assign word_idx = paddr[5:2];
  assign hit_std  = paddr[11:6] == `CF_OFS_FLT_STD >> 6;
  assign hit_ext  = paddr[11:6] == `CF_OFS_FLT_EXT >> 6;
  assign hit_mstd = paddr >= `CF_OFS_MSK_STD && paddr < `CF_OFS_MSK_EXT;
  assign hit_mext = paddr >= `CF_OFS_MSK_EXT && paddr < `CF_OFS_FULL_LO;
  assign hit_ptr  = paddr >= `CF_OFS_BUF_PTR && paddr < `CF_OFS_IRQ_STAT;

  logic [1:0] mi_std;
  logic [1:0] mi_ext;
  logic [1:0] pi;
  assign mi_std = 2'(paddr - `CF_OFS_MSK_STD >> 2);
  assign mi_ext = 2'(paddr - `CF_OFS_MSK_EXT >> 2);
  assign pi     = 2'(paddr - `CF_OFS_BUF_PTR >> 2);

  // read mux, unimplemented bits read zero
  // zero reserved bits
  always_comb begin
    rdata16 = 16'h0000;
    mapped  = 1'b1;
    if (paddr[1:0] != 2'b00) begin
      mapped = 1'b0;
    end else if (hit_std) begin
      rdata16 = flt_std_q[word_idx] & `CF_STD_WMASK;
    end else if (hit_ext) begin
      rdata16 = flt_ext_q[word_idx];
    end else if (hit_mstd) begin
      rdata16 = msk_std_q[mi_std] & `CF_STD_WMASK;
    end else if (hit_mext) begin
      rdata16 = msk_ext_q[mi_ext];
    end else if (hit_ptr) begin
      rdata16 = buf_ptr_q[pi*16 +: 16];
    end else begin
      case (paddr)
        `CF_OFS_MSEL_LO:  rdata16 = mask_sel_q[15:0];
        `CF_OFS_MSEL_HI:  rdata16 = mask_sel_q[31:16];
        `CF_OFS_FULL_LO:  rdata16 = rx_buffer_full_flag_q[15:0];
        `CF_OFS_FULL_HI:  rdata16 = rx_buffer_full_flag_q[31:16];
        `CF_OFS_OVF_LO:   rdata16 = rx_buffer_overflow_flag_q[15:0];
        `CF_OFS_OVF_HI:   rdata16 = rx_buffer_overflow_flag_q[31:16];
        `CF_OFS_FLT_EN:   rdata16 = filter_accept_enable_q;
        `CF_OFS_IRQ_STAT: rdata16 = {14'h0000, irq_stat_q};
        `CF_OFS_IRQ_MASK: rdata16 = {14'h0000, irq_mask_q};
        default:          mapped  = 1'b0;
      endcase
    end
  end

  assign pready  = 1'b1;
  assign pslverr = acc & ~mapped;
  assign prdata  = {16'h0000, rdata16};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NF; i++) begin
        flt_std_q[i] <= 16'h0000;
        flt_ext_q[i] <= 16'h0000;
      end
    end else if (wr && paddr[1:0] == 2'b00) begin
      if (hit_std) begin
        flt_std_q[word_idx] <= pwdata[15:0] & `CF_STD_WMASK;
      end
      if (hit_ext) begin
        flt_ext_q[word_idx] <= pwdata[15:0];
      end
    end
  end

  // mask storage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int m = 0; m < NM; m++) begin
        msk_std_q[m] <= 16'h0000;
        msk_ext_q[m] <= 16'h0000;
      end
    end else if (wr && paddr[1:0] == 2'b00) begin
      if (hit_mstd) begin
        msk_std_q[mi_std] <= pwdata[15:0] & `CF_STD_WMASK;
      end
      if (hit_mext) begin
        msk_ext_q[mi_ext] <= pwdata[15:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_sel_q <= 32'h00000000;
    end else if (wr && paddr == `CF_OFS_MSEL_LO) begin
      mask_sel_q[15:0] <= pwdata[15:0];
    end else if (wr && paddr == `CF_OFS_MSEL_HI) begin
      mask_sel_q[31:16] <= pwdata[15:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filter_accept_enable_q <= `CF_FLT_EN_RESET;
    end else if (wr && paddr == `CF_OFS_FLT_EN) begin
      filter_accept_enable_q <= pwdata[15:0];
    end
  end

  // buffer pointers, four filters per register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buf_ptr_q <= 64'h0000000000000000;
    end else if (wr && hit_ptr && paddr[1:0] == 2'b00) begin
      buf_ptr_q[pi*16 +: 16] <= pwdata[15:0];
    end
  end

  // per filter compare
  logic [NF-1:0] hit_vec;
  generate
    for (genvar f = 0; f < NF; f++) begin : g_filt
      logic [1:0]  src;
      logic [15:0] ms;
      logic [15:0] me;
      logic [10:0] fsid;
      logic [10:0] msid;
      logic [17:0] feid;
      logic [17:0] meid;
      logic        sid_ok;
      logic        eid_ok;
      logic        type_ok;
      assign src  = mask_sel_q[2*f +: 2];
      assign ms   = (src == can_filt_pkg::MASK_SRC_RSV) ? 16'h0000 :
                    msk_std_q[src];
      assign me   = (src == can_filt_pkg::MASK_SRC_RSV) ? 16'h0000 :
                    msk_ext_q[src];
      assign fsid = flt_std_q[f][15:`CF_STD_SID_LSB];
      assign msid = ms[15:`CF_STD_SID_LSB];
      assign feid = {flt_std_q[f][1:0], flt_ext_q[f]};
      assign meid = {ms[1:0], me};
      assign sid_ok = ((rx_sid ^ fsid) & msid) == 11'h000;
      assign eid_ok = !rx_ext || ((rx_eid ^ feid) & meid) == 18'h00000;
      assign type_ok = !ms[`CF_STD_TYPE_BIT] ||
                       (flt_std_q[f][`CF_STD_TYPE_BIT] == rx_ext);
      assign hit_vec[f] = filter_accept_enable_q[f] && sid_ok && eid_ok &&
                          type_ok && src != can_filt_pkg::MASK_SRC_RSV;
    end
  endgenerate

  logic [3:0] win;
  always_comb begin
    win = 4'h0;
    for (int i = NF - 1; i >= 0; i--) begin
      if (hit_vec[i]) begin
        win = 4'(i);
      end
    end
  end

  logic       accept;
  logic [3:0] win_ptr;
  logic [4:0] dest;
  assign accept  = rx_valid && (hit_vec != 16'h0000);
  assign win_ptr = buf_ptr_q[4*win +: 4];
  assign dest    = (win_ptr == `CF_PTR_FIFO) ? fifo_buffer_index :
                   {1'b0, win_ptr};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buf_wr_valid_q <= 1'b0;
      buf_wr_index_q <= 5'h00;
      hit_num_q      <= 5'h00;
    end else begin
      buf_wr_valid_q <= accept;
      if (accept) begin
        buf_wr_index_q <= dest;
        hit_num_q      <= {1'b0, win};
      end
    end
  end
  assign buf_wr_valid      = buf_wr_valid_q;
  assign buf_wr_index      = buf_wr_index_q;
  assign hit_filter_number = hit_num_q;

  logic [31:0] set_vec;
  logic [31:0] full_keep;
  logic [31:0] ovf_keep;
  assign set_vec   = accept ? (32'h00000001 << dest) : 32'h00000000;
  assign full_keep = !wr ? 32'hFFFFFFFF :
                     paddr == `CF_OFS_FULL_LO ? {16'hFFFF, pwdata[15:0]} :
                     paddr == `CF_OFS_FULL_HI ? {pwdata[15:0], 16'hFFFF} :
                     32'hFFFFFFFF;
  assign ovf_keep  = !wr ? 32'hFFFFFFFF :
                     paddr == `CF_OFS_OVF_LO ? {16'hFFFF, pwdata[15:0]} :
                     paddr == `CF_OFS_OVF_HI ? {pwdata[15:0], 16'hFFFF} :
                     32'hFFFFFFFF;

  // full set on write, set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_buffer_full_flag_q <= 32'h00000000;
    end else begin
      rx_buffer_full_flag_q <= (rx_buffer_full_flag_q & full_keep) | set_vec;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_buffer_overflow_flag_q <= 32'h00000000;
    end else begin
      rx_buffer_overflow_flag_q <= (rx_buffer_overflow_flag_q & ovf_keep) |
                                   (set_vec & rx_buffer_full_flag_q);
    end
  end

  // interrupt status, cleared by read, events win
  logic [1:0] irq_evt;
  assign irq_evt = {accept && |(set_vec & rx_buffer_full_flag_q), accept};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_q <= 2'b00;
    end else if (rd && paddr == `CF_OFS_IRQ_STAT) begin
      irq_stat_q <= irq_evt;
    end else begin
      irq_stat_q <= irq_stat_q | irq_evt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_q <= 2'b00;
    end else if (wr && paddr == `CF_OFS_IRQ_MASK) begin
      irq_mask_q <= pwdata[1:0];
    end
  end
  assign irq = |(irq_stat_q & irq_mask_q);

  // checks
  sequence s_accept;
    accept;
  endsequence
  sequence s_write_out;
    buf_wr_valid && !accept;
  endsequence

  a_full_set: assert property (@(posedge pclk) disable iff (!presetn)
    s_accept |=> rx_buffer_full_flag_q[$past(dest)])
    else $error("full flag not set after buffer write");
  a_ovf_set: assert property (@(posedge pclk) disable iff (!presetn)
    accept && rx_buffer_full_flag_q[dest] |=>
      rx_buffer_overflow_flag_q[$past(dest)])
    else $error("overflow flag not set on full buffer");
  a_ovf_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    !($past(wr) && ($past(paddr) == `CF_OFS_OVF_LO ||
      $past(paddr) == `CF_OFS_OVF_HI)) |->
      (rx_buffer_overflow_flag_q & $past(rx_buffer_overflow_flag_q)) ==
      $past(rx_buffer_overflow_flag_q))
    else $error("overflow flag fell without software clear");
  a_write_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    s_accept |=> buf_wr_valid && hit_filter_number == {1'b0, $past(win)}
      && buf_wr_index == $past(dest))
    else $error("buffer write request wrong");
  a_lowest_wins: assert property (@(posedge pclk) disable iff (!presetn)
    accept |-> hit_vec[win] && (hit_vec & ((16'h0001 << win) - 16'h0001))
      == 16'h0000)
    else $error("winning filter not lowest");
  a_disabled_off: assert property (@(posedge pclk) disable iff (!presetn)
    !filter_accept_enable_q[0] |-> !hit_vec[0])
    else $error("disabled filter hit");
  a_reserved_src: assert property (@(posedge pclk) disable iff (!presetn)
    mask_sel_q[1:0] == can_filt_pkg::MASK_SRC_RSV |-> !hit_vec[0])
    else $error("reserved mask source hit");
  a_type_check: assert property (@(posedge pclk) disable iff (!presetn)
    g_filt[0].ms[`CF_STD_TYPE_BIT] &&
      flt_std_q[0][`CF_STD_TYPE_BIT] != rx_ext |-> !hit_vec[0])
    else $error("frame type mismatch accepted");
  a_zero_bits: assert property (@(posedge pclk) disable iff (!presetn)
    rd && (hit_std || hit_mstd) |-> prdata[4] == 1'b0 && prdata[2] == 1'b0)
    else $error("unimplemented bits read nonzero");
  a_pulse_once: assert property (@(posedge pclk) disable iff (!presetn)
    s_write_out |=> !buf_wr_valid)
    else $error("write request held without new frame");
  a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
    irq_stat_q[`CF_IRQ_ACCEPT] && irq_mask_q[`CF_IRQ_ACCEPT] |-> irq)
    else $error("interrupt not raised");

endmodule
`default_nettype wire

// file: dv/can_rx_source.sv
// Purpose: bit-stream receiver stand-in offering decoded identifiers
// Assumes: one frame per call, one cycle pulse on rx_valid
// Notes:   lines show inverted last values between frames
`default_nettype none
module can_rx_source (
  // clock
  input  wire logic        pclk,
  // decoded frame
  output logic             rx_valid,
  output logic             rx_ext,
  output logic      [10:0] rx_sid,
  output logic      [17:0] rx_eid,
  output logic      [4:0]  fifo_buffer_index
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    rx_valid = 1'b0;
    rx_ext = 1'b0;
    rx_sid = 11'h000;
    rx_eid = 18'h00000;
    fifo_buffer_index = 5'h00;
  end

  task automatic send(input logic x, input logic [10:0] s,
                      input logic [17:0] e, input logic [4:0] fi);
    @(posedge pclk);
    rx_valid <= 1'b1;
    rx_ext <= x;
    rx_sid <= s;
    rx_eid <= e;
    fifo_buffer_index <= fi;
    @(posedge pclk);
    // stale values must not pass for a frame
    rx_valid <= 1'b0;
    rx_ext <= ~x;
    rx_sid <= ~s;
    rx_eid <= ~e;
    fifo_buffer_index <= ~fi;
  endtask
endmodule
`default_nettype wire

// file: dv/testbench.sv
// Purpose: self-checking bench of the acceptance filter
// Assumes: zero-wait APB, result one cycle after a frame
// Notes:   random setup from an lfsr, expectations from shadow state
`include "can_filt_defs.svh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, d, r, q;
  logic        pready, pslverr, er, rx_valid, rx_ext, buf_wr_valid, irq;
  logic [10:0] rx_sid;
  logic [17:0] rx_eid;
  logic [4:0]  fifo_buffer_index, buf_wr_index, hit_filter_number;
  logic [31:0] seed = 32'h5CA2E388;
  logic [15:0] fstd [16], fext [16], mstd [3], mext [3], fen;
  logic [31:0] msel;
  logic [63:0] ptr, flg;
  logic [1:0]  ist, imask;
  logic [11:0] zaddr [9] = '{`CF_OFS_MSEL_LO, `CF_OFS_MSEL_HI,
    `CF_OFS_FULL_LO, `CF_OFS_FULL_HI, `CF_OFS_OVF_LO, `CF_OFS_OVF_HI,
    `CF_OFS_BUF_PTR, `CF_OFS_IRQ_STAT, `CF_OFS_IRQ_MASK};
  logic [15:0] fens [3] = '{16'h0000, 16'h8000, 16'h0007};
  int          err_total, check_count, cycles, f;

  can_acceptance_filter_rx_status uut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_valid(rx_valid), .rx_ext(rx_ext), .rx_sid(rx_sid),
    .rx_eid(rx_eid), .fifo_buffer_index(fifo_buffer_index),
    .buf_wr_valid(buf_wr_valid), .buf_wr_index(buf_wr_index),
    .hit_filter_number(hit_filter_number), .irq(irq));
  can_rx_source src (.pclk(pclk), .rx_valid(rx_valid), .rx_ext(rx_ext),
    .rx_sid(rx_sid), .rx_eid(rx_eid),
    .fifo_buffer_index(fifo_buffer_index));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction

  // lowest enabled filter whose included bits and type agree
  function automatic int find_hit(input logic x, input logic [10:0] s,
                                  input logic [17:0] e);
    logic [1:0]  m;
    logic [15:0] fs, ms;
    logic        so, eo;
    for (int i = 0; i < 16; i++) begin
      m = msel[2*i+:2];
      if (m == 2'b11) continue;
      fs = fstd[i];
      ms = mstd[m];
      so = ((s ^ fs[15:5]) & ms[15:5]) == 11'h000;
      eo = ((e ^ {fs[1:0], fext[i]}) & {ms[1:0], mext[m]}) == 18'h00000;
      if (fen[i] && so && (!x || eo) && (!ms[3] || x == fs[3])) begin
        return i;
      end
    end
    return -1;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] wd);
    logic rdy;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // settled answer taken just before the access edge
    do begin
      @(negedge pclk);
      rdy = pready;
      rd = prdata;
      er = pslverr;
      @(posedge pclk);
    end while (rdy !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  task automatic frame(input logic x, input logic [10:0] s,
                       input logic [17:0] e, input logic [4:0] fi);
    int         h;
    logic [4:0] b;
    h = find_hit(x, s, e);
    src.send(x, s, e, fi);
    @(negedge pclk);
    chk(buf_wr_valid, h >= 0);
    if (h >= 0) begin
      b = ptr[4*h+:4] == `CF_PTR_FIFO ? fi : {1'b0, ptr[4*h+:4]};
      chk(buf_wr_index, b);
      chk(hit_filter_number, 5'(h));
      ist = ist | {flg[b], 1'b1};
      flg[32+b] = flg[32+b] | flg[b];
      flg[b] = 1'b1;
    end
    chk(irq, |(ist & imask));
  endtask

  task automatic flags();
    for (int k = 0; k < 4; k++) begin
      rdc(`CF_OFS_FULL_LO + 12'(4*k), {16'h0, flg[16*k+:16]});
    end
  endtask

  task automatic complete_run();
    $display("checks=%0d errors=%0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      err_total++;
      complete_run();
    end
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    {err_total, check_count, cycles, ist, imask, flg, msel, ptr} = '0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rdc(`CF_OFS_FLT_EN, `CF_FLT_EN_RESET);
    foreach (zaddr[i]) rdc(zaddr[i], 32'h0);
    apb(1'b0, 12'hFFC, 32'h0);
    chk({rd[30:0], er}, 32'h1);
    apb(1'b1, 12'h002, 32'hFFFF);
    chk(er, 1'b1);
    for (int i = 0; i < 16; i++) begin
      d = rnd();
      apb(1'b1, `CF_OFS_FLT_STD + 12'(4*i), d);
      fstd[i] = d[15:0] & `CF_STD_WMASK;
      rdc(`CF_OFS_FLT_STD + 12'(4*i), {16'h0, fstd[i]});
      fext[i] = 16'(rnd());
      apb(1'b1, `CF_OFS_FLT_EXT + 12'(4*i), {16'h0, fext[i]});
      msel[2*i+:2] = 2'(rnd() % 3);
      ptr[4*i+:4] = 4'(rnd());
    end
    for (int m = 0; m < 3; m++) begin
      d = rnd();
      apb(1'b1, `CF_OFS_MSK_STD + 12'(4*m), d);
      mstd[m] = d[15:0] & `CF_STD_WMASK;
      rdc(`CF_OFS_MSK_STD + 12'(4*m), {16'h0, mstd[m]});
      mext[m] = 16'(rnd());
      apb(1'b1, `CF_OFS_MSK_EXT + 12'(4*m), {16'h0, mext[m]});
    end
    apb(1'b1, `CF_OFS_MSEL_LO, {16'h0, msel[15:0]});
    apb(1'b1, `CF_OFS_MSEL_HI, {16'h0, msel[31:16]});
    rdc(`CF_OFS_MSEL_HI, {16'h0, msel[31:16]});
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, `CF_OFS_BUF_PTR + 12'(4*k), {16'h0, ptr[16*k+:16]});
    end
    fen = 16'(rnd() | rnd());
    apb(1'b1, `CF_OFS_FLT_EN, {16'h0, fen});
    imask = 2'b11;
    apb(1'b1, `CF_OFS_IRQ_MASK, 32'h3);
    repeat (300) begin
      f = rnd() % 16;
      r = rnd() & rnd() & rnd() & rnd();
      q = rnd();
      frame(q[0], fstd[f][15:5] ^ r[10:0],
            {fstd[f][1:0], fext[f]} ^ r[28:11], q[5:1]);
    end
    flags();
    rdc(`CF_OFS_IRQ_STAT, {30'h0, ist});
    ist = 2'b00;
    @(negedge pclk);
    chk(irq, 1'b0);
    // software clears; ones written keep the flags
    for (int k = 0; k < 4; k++) begin
      d = rnd();
      apb(1'b1, `CF_OFS_FULL_LO + 12'(4*k), d);
      flg[16*k+:16] = flg[16*k+:16] & d[15:0];
    end
    flags();
    // masks all don't care: every enabled filter except filter 0 hits, lowest wins
    for (int m = 0; m < 3; m++) begin
      mstd[m] = 16'h0;
      mext[m] = 16'h0;
      apb(1'b1, `CF_OFS_MSK_STD + 12'(4*m), 32'h0);
      apb(1'b1, `CF_OFS_MSK_EXT + 12'(4*m), 32'h0);
    end
    imask = 2'b10;
    apb(1'b1, `CF_OFS_IRQ_MASK, 32'h2);
    // reserved source on filter 0: it must never hit
    msel[1:0] = 2'b11;
    apb(1'b1, `CF_OFS_MSEL_LO, {16'h0, msel[15:0]});
    foreach (fens[i]) begin
      fen = fens[i];
      apb(1'b1, `CF_OFS_FLT_EN, {16'h0, fen});
      repeat (3) begin
        q = rnd();
        frame(q[0], q[11:1], q[29:12], q[31:27]);
      end
    end
    flags();
    complete_run();
  end
endmodule
`default_nettype wire
